// [verilog/bhw_consts.vh]
// constants for the bridge header window register bank
// assumes dword-addressed configuration accesses with byte enables
`ifndef BHW_CONSTS_VH
`define BHW_CONSTS_VH
`define BHW_OFS_PREFETCH_BASE_HIGH 8'h28
`define BHW_OFS_PREFETCH_LIMIT_HIGH 8'h2C
`define BHW_OFS_IO_WINDOW_BASE_HIGH 8'h30
`define BHW_OFS_IO_WINDOW_LIMIT_HIGH 8'h32
`define BHW_OFS_CAPABILITY_LIST 8'h34
`define BHW_OFS_IRQ_ROUTING 8'h3C
`define BHW_OFS_IRQ_PIN 8'h3D
`define BHW_OFS_BRIDGE_CONTROL 8'h3E
`define BHW_RST_PREFETCH_HIGH 32'h0000_0000
`define BHW_RST_IO_HIGH 16'h0000
`define BHW_CAPABILITY_PTR 8'h40
`define BHW_RST_IRQ_ROUTING 8'hFF
`define BHW_IRQ_PIN_VALUE 8'h00
`define BHW_RST_BRIDGE_CONTROL 16'h0000
`define BHW_BCTL_RW_MASK 16'h0BFF
`define BHW_BCTL_DT_STATUS_BIT 10
`define BHW_LOW20_ZERO 20'h0_0000
`define BHW_LOW20_ONES 20'hF_FFFF
`endif

// [verilog/bhw_bridge_header_window_regs.v]
// upper window, pointer, interrupt and bridge control registers of a bridge header
// assumes a configuration port that presents one dword access per strobe, synchronous to core_clk
`include "bhw_consts.vh"

// Behaviour
// - read/write 32-bit prefetch base high at 28h, resets zero.
// - read/write 32-bit prefetch limit high at 2Ch, resets zero.
// - read/write 16-bit I/O base high at 30h, low 20 bits zero.
// - read/write 16-bit I/O limit high at 32h, low 20 bits ones.
// - capability pointer at 34h always reads 40h.
// - interrupt line scratch at 3Ch, resets FFh, no internal effect.
// - interrupt pin at 3Dh always reads 00h.
// - secondary interrupts pass through to primary interface.
// - bridge control at 3Eh resets 0000h, mixes read-only, read/write, clear fields.
// - lower prefetch base/limit bits 31:20 join upper words into 64-bit addresses.
module bhw_bridge_header_window_regs #(
	parameter INTX_WIDTH = 4
) (
	input wire core_clk,
	input wire rst,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_rd_valid,
	input wire [11:0] prefetch_window_base_low,
	input wire [11:0] prefetch_window_limit_low,
	input wire discard_timer_expired,
	input wire [63:0] txn_mem_addr,
	input wire [31:0] txn_io_addr,
	output reg prefetch_window_hit,
	output reg io_window_hit,
	output reg [15:0] bridge_control,
	input wire [INTX_WIDTH-1:0] sec_intx,
	output reg [INTX_WIDTH-1:0] pri_intx
);

	reg [31:0] prefetch_window_base_high;
	reg [31:0] prefetch_window_limit_high;
	reg [15:0] io_window_base_high;
	reg [15:0] io_window_limit_high;
	reg [7:0] irq_routing_scratch;
	reg [31:0] next_rdata;
	wire [7:0] dword_addr;
	wire [63:0] prefetch_base_full;
	wire [63:0] prefetch_limit_full;
	wire [31:0] io_base_full;
	wire [31:0] io_limit_full;
	wire wr_pb;
	wire wr_pl;
	wire wr_io;
	wire wr_ctl;
	wire dt_clear;

	// byte-lane merge, shared by the window and interrupt line registers; bridge control is written directly
	function [7:0] merge8;
		input [7:0] old_v;
		input [7:0] new_v;
		input en;
		begin
			merge8 = en ? new_v : old_v;
		end
	endfunction

	assign dword_addr = {cfg_addr[7:2], 2'b00};
	assign wr_pb = cfg_wr && (dword_addr == `BHW_OFS_PREFETCH_BASE_HIGH);
	assign wr_pl = cfg_wr && (dword_addr == `BHW_OFS_PREFETCH_LIMIT_HIGH);
	assign wr_io = cfg_wr && (dword_addr == `BHW_OFS_IO_WINDOW_BASE_HIGH);
	assign wr_ctl = cfg_wr && (dword_addr == `BHW_OFS_IRQ_ROUTING);
	// status bit is write-one-to-clear in the upper byte lane
	assign dt_clear = wr_ctl && cfg_be[3] && cfg_wdata[16 + `BHW_BCTL_DT_STATUS_BIT];

	always @(posedge core_clk) begin
		if (rst) begin
			prefetch_window_base_high <= `BHW_RST_PREFETCH_HIGH;
			prefetch_window_limit_high <= `BHW_RST_PREFETCH_HIGH;
			io_window_base_high <= `BHW_RST_IO_HIGH;
			io_window_limit_high <= `BHW_RST_IO_HIGH;
			irq_routing_scratch <= `BHW_RST_IRQ_ROUTING;
			bridge_control <= `BHW_RST_BRIDGE_CONTROL;
		end else begin
			if (wr_pb) begin
				prefetch_window_base_high[7:0] <= merge8(prefetch_window_base_high[7:0], cfg_wdata[7:0], cfg_be[0]);
				prefetch_window_base_high[15:8] <= merge8(prefetch_window_base_high[15:8], cfg_wdata[15:8], cfg_be[1]);
				prefetch_window_base_high[23:16] <= merge8(prefetch_window_base_high[23:16], cfg_wdata[23:16], cfg_be[2]);
				prefetch_window_base_high[31:24] <= merge8(prefetch_window_base_high[31:24], cfg_wdata[31:24], cfg_be[3]);
			end
			if (wr_pl) begin
				prefetch_window_limit_high[7:0] <= merge8(prefetch_window_limit_high[7:0], cfg_wdata[7:0], cfg_be[0]);
				prefetch_window_limit_high[15:8] <= merge8(prefetch_window_limit_high[15:8], cfg_wdata[15:8], cfg_be[1]);
				prefetch_window_limit_high[23:16] <= merge8(prefetch_window_limit_high[23:16], cfg_wdata[23:16], cfg_be[2]);
				prefetch_window_limit_high[31:24] <= merge8(prefetch_window_limit_high[31:24], cfg_wdata[31:24], cfg_be[3]);
			end
			if (wr_io) begin
				io_window_base_high[7:0] <= merge8(io_window_base_high[7:0], cfg_wdata[7:0], cfg_be[0]);
				io_window_base_high[15:8] <= merge8(io_window_base_high[15:8], cfg_wdata[15:8], cfg_be[1]);
				io_window_limit_high[7:0] <= merge8(io_window_limit_high[7:0], cfg_wdata[23:16], cfg_be[2]);
				io_window_limit_high[15:8] <= merge8(io_window_limit_high[15:8], cfg_wdata[31:24], cfg_be[3]);
			end
			if (wr_ctl) begin
				irq_routing_scratch <= merge8(irq_routing_scratch, cfg_wdata[7:0], cfg_be[0]);
			end
			// read/write fields only; reserved bits stay zero
			if (wr_ctl && cfg_be[2]) begin
				bridge_control[7:0] <= cfg_wdata[23:16];
			end
			if (wr_ctl && cfg_be[3]) begin
				bridge_control[11] <= cfg_wdata[27];
				bridge_control[9:8] <= cfg_wdata[25:24];
			end
			// set wins over a clear in the same cycle
			if (discard_timer_expired) begin
				bridge_control[`BHW_BCTL_DT_STATUS_BIT] <= 1'b1;
			end else if (dt_clear) begin
				bridge_control[`BHW_BCTL_DT_STATUS_BIT] <= 1'b0;
			end
		end
	end

	always @* begin
		next_rdata = 32'h0000_0000;
		case (dword_addr)
			`BHW_OFS_PREFETCH_BASE_HIGH: next_rdata = prefetch_window_base_high;
			`BHW_OFS_PREFETCH_LIMIT_HIGH: next_rdata = prefetch_window_limit_high;
			`BHW_OFS_IO_WINDOW_BASE_HIGH: next_rdata = {io_window_limit_high, io_window_base_high};
			`BHW_OFS_CAPABILITY_LIST: next_rdata = {24'h00_0000, `BHW_CAPABILITY_PTR};
			`BHW_OFS_IRQ_ROUTING: next_rdata = {bridge_control, `BHW_IRQ_PIN_VALUE, irq_routing_scratch};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_rd_valid <= 1'b0;
		end else begin
			cfg_rd_valid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// full window bounds; only bits 11:0 of each I/O high half reach address bits 31:20
	assign prefetch_base_full = {prefetch_window_base_high, prefetch_window_base_low, `BHW_LOW20_ZERO};
	assign prefetch_limit_full = {prefetch_window_limit_high, prefetch_window_limit_low, `BHW_LOW20_ONES};
	assign io_base_full = {io_window_base_high[11:0], `BHW_LOW20_ZERO};
	assign io_limit_full = {io_window_limit_high[11:0], `BHW_LOW20_ONES};

	always @(posedge core_clk) begin
		if (rst) begin
			prefetch_window_hit <= 1'b0;
			io_window_hit <= 1'b0;
			pri_intx <= {INTX_WIDTH{1'b0}};
		end else begin
			prefetch_window_hit <= (txn_mem_addr >= prefetch_base_full) && (txn_mem_addr <= prefetch_limit_full);
			io_window_hit <= (txn_io_addr >= io_base_full) && (txn_io_addr <= io_limit_full);
			pri_intx <= sec_intx;
		end
	end

endmodule // bhw_bridge_header_window_regs

// [testbench/bhw_props.sv]
// assertions, header window regs
// assumes bind to the bank top ports
module bhw_props #(parameter INTX_WIDTH = 4) (
	input wire core_clk,
	input wire rst,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_rdata,
	input wire cfg_rd_valid,
	input wire discard_timer_expired,
	input wire [15:0] bridge_control,
	input wire [INTX_WIDTH-1:0] sec_intx,
	input wire [INTX_WIDTH-1:0] pri_intx
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_RD_VALID: assert property (cfg_rd |=> cfg_rd_valid) else $error("no valid");
	AST_RV: assert property (cfg_rd_valid |-> $past(cfg_rd)) else $error("stray");
	AST_HOLD: assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("moved");
	AST_CAP: assert property (cfg_rd && cfg_addr == 8'h34 |=> cfg_rdata == 32'h0000_0040) else $error("ptr");
	AST_PIN: assert property (cfg_rd && cfg_addr == 8'h3C |=> cfg_rdata[15:8] == 8'h00) else $error("pin");
	AST_RSVD: assert property (cfg_rd && cfg_addr == 8'h3C |=> cfg_rdata[31:28] == 4'h0) else $error("rsvd");
	AST_DT: assert property (discard_timer_expired |-> ##[1:2] bridge_control[10]) else $error("status");
	AST_INTX: assert property (!$past(rst) |-> pri_intx == $past(sec_intx)) else $error("intx");
endmodule // bhw_props
bind bhw_bridge_header_window_regs bhw_props #(.INTX_WIDTH(INTX_WIDTH)) props_i (.*);

// [testbench/testbench.sv]
// self-checking bench, header window regs
// assumes one clock, one-cycle strobes
module testbench;
	timeunit 1ns / 1ps;
	logic core_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, discard_timer_expired = 0;
	logic cfg_rd_valid, prefetch_window_hit, io_window_hit;
	logic [7:0] cfg_addr = 0;
	logic [3:0] cfg_be = 0, sec_intx = 0, pri_intx;
	logic [31:0] cfg_wdata = 0, txn_io_addr = 0, cfg_rdata;
	logic [63:0] txn_mem_addr = 0;
	logic [15:0] bridge_control;
	int fails = 0, checks_done = 0;
	always #5 core_clk = ~core_clk;
	bhw_bridge_header_window_regs DUT (.prefetch_window_base_low(12'h001), .prefetch_window_limit_low(12'h002), .*);
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		fails += (g !== e);
		if (g !== e) $display("wrong value %s exp %h got %h", n, e, g);
	endtask
	task rw(logic w, logic [7:0] a, logic [3:0] b, logic [31:0] d);
		{cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {w, !w, a, b, d};
		@(posedge core_clk);
		{cfg_wr, cfg_rd} <= 2'b00;
		@(negedge core_clk);
		if (!w) chk("rd_valid", 32'h0000_0001, {31'h0, cfg_rd_valid});
		if (!w) chk("rdata", d, cfg_rdata);
		@(negedge core_clk);
		@(posedge core_clk);
	endtask
	task hit(logic [63:0] m, logic [31:0] i, logic [1:0] e);
		{txn_mem_addr, txn_io_addr} <= {m, i};
		repeat (2) @(negedge core_clk);
		chk("hits", e, {prefetch_window_hit, io_window_hit});
		@(posedge core_clk);
	endtask
	task results;
		$display("fails %0d checks %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20000 fails++;
		results;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		{rst, sec_intx} <= {1'b0, 4'hA};
		rw(0, 8'h34, 0, 32'h0000_0040);
		rw(0, 8'h3C, 0, 32'h0000_00FF);
		rw(1, 8'h28, 4'h2, 32'hFFFF_FFFF);
		rw(0, 8'h28, 0, 32'h0000_FF00);
		rw(1, 8'h2C, 4'hF, 32'h0000_0001);
		rw(1, 8'h28, 4'hF, 32'h0000_0001);
		rw(1, 8'h30, 4'hF, 32'h0001_0001);
		rw(1, 8'h3C, 4'hF, 32'hFFFF_FF5A);
		discard_timer_expired <= 1;
		@(posedge core_clk) discard_timer_expired <= 0;
		rw(0, 8'h3C, 0, 32'h0FFF_005A);
		rw(1, 8'h3C, 4'h8, 32'h0400_0000);
		rw(0, 8'h3C, 0, 32'h00FF_005A);
		hit(64'h0000_0001_0010_0000, 32'h0010_0000, 2'b11);
		hit(64'h0000_0001_002F_FFFF, 32'h001F_FFFF, 2'b11);
		hit(64'h0000_0001_000F_FFFF, 32'h002F_FFFF, 2'b00);
		chk("bridge_control", 32'h0000_00FF, {16'h0, bridge_control});
		chk("pri_intx", 32'h0000_000A, {28'h0, pri_intx});
		rst <= 1;
		@(posedge core_clk) rst <= 0;
		rw(0, 8'h28, 0, 32'h0000_0000);
		rw(0, 8'h3C, 0, 32'h0000_00FF);
		chk("bridge_control", 32'h0000_0000, {16'h0, bridge_control});
		results;
	end
endmodule // testbench
